// [shared/mioc_pkg.sv]
`default_nettype none
package mioc_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NPORTS = 12;
  localparam int MODE_W = 4;
  localparam int CODE_W = 12;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 4;
  localparam int MON_W = 3;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_GPI_DATA = 8'h0b;
  localparam logic [7:0] OFS_GPO_DATA = 8'h0d;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_PRESET_ONE = 8'h16;
  localparam logic [7:0] OFS_PRESET_TWO = 8'h17;
  localparam logic [7:0] OFS_ADC_BASE = 8'h40;
  localparam logic [7:0] OFS_ADC_END = 8'h4c;
  localparam logic [7:0] OFS_DAC_BASE = 8'h60;
  localparam logic [7:0] OFS_DAC_END = 8'h6c;

  // ------------------------------------------------------------
  // Control word fields
  // ------------------------------------------------------------
  localparam int CTL_DAC_MODE_LO = 2;
  localparam int CTL_THSD = 7;
  localparam int CTL_MON_LO = 8;
  localparam int CTL_LP = 13;
  localparam int CTL_BURST = 14;
  localparam int CTL_SOFT_RST = 15;
  localparam logic [1:0] DAC_MODE_PRESET_ONE = 2'b10;
  localparam logic [1:0] DAC_MODE_PRESET_TWO = 2'b11;
  // Port modes 1, 3, 4, 5, 6 and 10 are output-converter modes
  localparam logic [15:0] DAC_MODE_MASK = 16'h047a;

  // ------------------------------------------------------------
  // Level word layout
  // ------------------------------------------------------------
  localparam int LVL_LO_POS = 2;
  localparam int LVL_MID_POS = 11;
  localparam int LVL_TOP_POS = 0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [11:0] GPO_RESET = 12'h000;
  localparam logic [11:0] PRESET_RESET = 12'h000;
  localparam logic [11:0] CODE_RESET = 12'h000;

  // ------------------------------------------------------------
  // Thermal limit, temperature in 1/8 degree steps
  // ------------------------------------------------------------
  localparam int TSHDN_LIMIT_C = 145;
  localparam int TEMP_LSB_PER_C = 8;
  localparam logic signed [11:0] TSHDN_LIMIT_CODE = 12'(TSHDN_LIMIT_C * TEMP_LSB_PER_C);

  function automatic logic [15:0] mioc_pack(input logic [11:0] lvl);
    logic [15:0] w;
    w = 16'h0000;
    w[LVL_LO_POS +: 6] = lvl[5:0];
    w[LVL_MID_POS +: 5] = lvl[10:6];
    w[LVL_TOP_POS] = lvl[11];
    return w;
  endfunction

  function automatic logic [11:0] mioc_unpack(input logic [15:0] w);
    logic [11:0] lvl;
    lvl = 12'h000;
    lvl[5:0] = w[LVL_LO_POS +: 6];
    lvl[10:6] = w[LVL_MID_POS +: 5];
    lvl[11] = w[LVL_TOP_POS];
    return lvl;
  endfunction
endpackage
`default_nettype wire

// [shared/mioc_mem_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface mioc_mem_if;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [11:0] wr_data;
  logic [3:0] rd_idx;
  logic [11:0] rd_data;
  logic clr;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, output clr,
                input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, input clr,
               output rd_data);
endinterface
`default_nettype wire

// [core/mioc_dac_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module mioc_dac_mem #(
  parameter int DEPTH = mioc_pkg::NPORTS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Access
  mioc_mem_if.mem bus
);
  logic [11:0] word_reg [DEPTH];
  logic [11:0] rd_data_reg;
  logic [11:0] rd_next;

  // ------------------------------------------------------------
  // Entries
  // ------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    wire hit = bus.wr_en && (bus.wr_idx == 4'(i));
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        word_reg[i] <= mioc_pkg::CODE_RESET;
      else if (bus.clr)
        word_reg[i] <= mioc_pkg::CODE_RESET;
      else if (hit)
        word_reg[i] <= bus.wr_data;
    end
  end

  // ------------------------------------------------------------
  // Registered read
  // ------------------------------------------------------------
  assign rd_next = (32'(bus.rd_idx) < DEPTH) ? word_reg[bus.rd_idx] : 12'h000;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_reg <= mioc_pkg::CODE_RESET;
    else
      rd_data_reg <= rd_next;
  end

  assign bus.rd_data = rd_data_reg;
endmodule // mioc_dac_mem
`default_nettype wire

// [core/mioc_regs.sv]
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Thermal enable plus internal monitor and temperature above 145 C resets the device.
// - That reset sets analog ports high impedance and all registers to defaults.
// - With thermal enable clear, temperature never causes a reset.
// - Monitor field bits 10:8 enable internal, first and second external monitors.
// - Power mode bit 13 set holds analog ports high impedance; clear is normal.
// - Clearing the power mode bit starts the regular power-on sequence.
// - Burst bit 14 clear: address advances by one after each burst word.
// - Burst bit set: converter reads and output data writes visit matching ports only.
// - Output-converter data reads always step by one.
// - Soft reset bit 15 acts as power-on reset and clears itself.
// - Input data word shows sampled level of each input-configured port.
// - Input levels: ports 0-5 bits 7:2, 6-10 bits 15:11, 11 bit 0.
// - Written output levels drive each output-configured port.
// - Output levels use the same layout and read back.
// - Two twelve-bit presets serve every output-converter mode port.
// - Preset writes leave per-port output-converter data untouched.
// - Converter mode 10 selects preset one, 11 selects preset two.
module mioc_regs #(
  parameter logic [15:0] ADC_MODE_MASK = 16'h0380,
  parameter logic [15:0] GPI_MODE_MASK = 16'h0800,
  parameter logic [15:0] GPO_MODE_MASK = 16'h1000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial word access
  input wire logic acc_start,
  input wire logic [7:0] acc_addr,
  input wire logic acc_write,
  input wire logic acc_word,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] acc_rdata,
  output logic acc_rvalid,
  output logic [7:0] acc_cur_addr,
  // Port side
  input wire logic [47:0] port_mode,
  input wire logic [11:0] port_in_level,
  input wire logic [143:0] adc_result,
  output logic [11:0] port_out_level,
  output logic analog_hiz,
  // Temperature
  input wire logic temp_valid,
  input wire logic signed [11:0] int_temp,
  // Control outputs
  output logic [15:0] ctrl_word,
  output logic [2:0] monitor_enable,
  output logic dac_use_preset,
  output logic [11:0] dac_preset_code,
  output logic dev_reset,
  output logic powerup_seq
);
  localparam int NP = mioc_pkg::NPORTS;
  localparam int MW = mioc_pkg::MODE_W;
  localparam int CW = mioc_pkg::CODE_W;

  logic [15:0] ctrl_reg, ctrl_next;
  logic [11:0] gpo_reg, gpo_next;
  logic [11:0] pre1_reg, pre1_next;
  logic [11:0] pre2_reg, pre2_next;
  logic [7:0] cur_addr_reg, cur_addr_next;
  logic [7:0] rd_addr_reg;
  logic clr_req_reg, clr_req_next;
  logic dev_reset_reg, rd_pend_reg, acc_rvalid_reg;
  logic [15:0] acc_rdata_reg;
  logic hiz_reg, powerup_reg, use_preset_reg;
  logic [11:0] out_level_reg, preset_code_reg;
  logic [11:0] is_dac, is_adc, is_gpi, is_gpo;
  logic [11:0] adc_arr [NP];
  mioc_mem_if mem_bus ();

  // ------------------------------------------------------------
  // Per-port mode decode
  // ------------------------------------------------------------
  for (genvar i = 0; i < NP; i++) begin : g_port
    wire [3:0] mode = port_mode[i*MW +: MW];
    assign is_dac[i] = mioc_pkg::DAC_MODE_MASK[mode];
    assign is_adc[i] = ADC_MODE_MASK[mode];
    assign is_gpi[i] = GPI_MODE_MASK[mode];
    assign is_gpo[i] = GPO_MODE_MASK[mode];
    assign adc_arr[i] = adc_result[i*CW +: CW];
  end

  // First port above idx whose bit is set; 12 when none remain
  function automatic logic [4:0] next_port(input logic [11:0] sel, input logic [3:0] idx);
    logic [4:0] r;
    r = 5'd12;
    for (int j = NP - 1; j >= 0; j--)
      if (j > 32'(idx) && sel[j])
        r = 5'(j);
    return r;
  endfunction

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  wire word_ok = acc_word && !acc_start;
  wire wr_word = word_ok && acc_write;
  wire rd_word = word_ok && !acc_write;
  wire hit_ctl = cur_addr_reg == mioc_pkg::OFS_CTRL;
  wire hit_gpo = cur_addr_reg == mioc_pkg::OFS_GPO_DATA;
  wire hit_pre1 = cur_addr_reg == mioc_pkg::OFS_PRESET_ONE;
  wire hit_pre2 = cur_addr_reg == mioc_pkg::OFS_PRESET_TWO;
  wire in_adc = cur_addr_reg >= mioc_pkg::OFS_ADC_BASE && cur_addr_reg < mioc_pkg::OFS_ADC_END;
  wire in_dac = cur_addr_reg >= mioc_pkg::OFS_DAC_BASE && cur_addr_reg < mioc_pkg::OFS_DAC_END;
  wire [3:0] adc_idx = 4'(cur_addr_reg - mioc_pkg::OFS_ADC_BASE);
  wire [3:0] dac_idx = 4'(cur_addr_reg - mioc_pkg::OFS_DAC_BASE);
  wire wr_ctl = wr_word && hit_ctl;
  wire soft_req = wr_ctl && acc_wdata[mioc_pkg::CTL_SOFT_RST];
  wire burst_ctx = ctrl_reg[mioc_pkg::CTL_BURST];

  // ------------------------------------------------------------
  // Burst address stepping
  // ------------------------------------------------------------
  // Output data reads never take the contextual path
  wire ctx_adc = burst_ctx && rd_word && in_adc;
  wire ctx_dac = burst_ctx && wr_word && in_dac;
  wire [7:0] adc_jump = mioc_pkg::OFS_ADC_BASE + {3'b000, next_port(is_adc, adc_idx)};
  wire [7:0] dac_jump = mioc_pkg::OFS_DAC_BASE + {3'b000, next_port(is_dac, dac_idx)};
  wire [7:0] addr_inc = 8'(cur_addr_reg + 8'h01);
  assign cur_addr_next = acc_start ? acc_addr :
                         !word_ok ? cur_addr_reg :
                         ctx_adc ? adc_jump :
                         ctx_dac ? dac_jump : addr_inc;

  // ------------------------------------------------------------
  // Thermal trip and soft reset
  // ------------------------------------------------------------
  // A pending clear masks the trip, so one overheat gives a single reset pulse
  wire trip = ctrl_reg[mioc_pkg::CTL_THSD] && ctrl_reg[mioc_pkg::CTL_MON_LO] &&
              temp_valid && (int_temp > mioc_pkg::TSHDN_LIMIT_CODE) && !clr_req_reg;
  assign clr_req_next = soft_req || trip;

  // ------------------------------------------------------------
  // Register next values
  // ------------------------------------------------------------
  // Reset bit is never stored, so it always reads back zero
  assign ctrl_next = clr_req_reg ? mioc_pkg::CTL_RESET :
                     wr_ctl ? {1'b0, acc_wdata[14:0]} : ctrl_reg;
  assign gpo_next = clr_req_reg ? mioc_pkg::GPO_RESET :
                    (wr_word && hit_gpo) ? mioc_pkg::mioc_unpack(acc_wdata) : gpo_reg;
  assign pre1_next = clr_req_reg ? mioc_pkg::PRESET_RESET :
                     (wr_word && hit_pre1) ? acc_wdata[11:0] : pre1_reg;
  assign pre2_next = clr_req_reg ? mioc_pkg::PRESET_RESET :
                     (wr_word && hit_pre2) ? acc_wdata[11:0] : pre2_reg;
  wire lp_exit = wr_ctl && ctrl_reg[mioc_pkg::CTL_LP] &&
                 !acc_wdata[mioc_pkg::CTL_LP] && !clr_req_reg;
  wire [1:0] dac_mode = ctrl_reg[mioc_pkg::CTL_DAC_MODE_LO +: 2];

  // ------------------------------------------------------------
  // Per-port converter data store
  // ------------------------------------------------------------
  assign mem_bus.wr_en = wr_word && in_dac && !clr_req_reg;
  assign mem_bus.wr_idx = dac_idx;
  assign mem_bus.wr_data = acc_wdata[11:0];
  assign mem_bus.rd_idx = dac_idx;
  assign mem_bus.clr = clr_req_reg;

  mioc_dac_mem #(
    .DEPTH(NP)
  ) u_dac_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(mem_bus.mem)
  );

  // ------------------------------------------------------------
  // Read data select, one cycle behind the word
  // ------------------------------------------------------------
  wire rh_ctl = rd_addr_reg == mioc_pkg::OFS_CTRL;
  wire rh_gpi = rd_addr_reg == mioc_pkg::OFS_GPI_DATA;
  wire rh_gpo = rd_addr_reg == mioc_pkg::OFS_GPO_DATA;
  wire rh_p1 = rd_addr_reg == mioc_pkg::OFS_PRESET_ONE;
  wire rh_p2 = rd_addr_reg == mioc_pkg::OFS_PRESET_TWO;
  wire rh_adc = rd_addr_reg >= mioc_pkg::OFS_ADC_BASE && rd_addr_reg < mioc_pkg::OFS_ADC_END;
  wire rh_dac = rd_addr_reg >= mioc_pkg::OFS_DAC_BASE && rd_addr_reg < mioc_pkg::OFS_DAC_END;
  wire [3:0] rd_adc_idx = 4'(rd_addr_reg - mioc_pkg::OFS_ADC_BASE);
  wire [11:0] gpi_seen = port_in_level & is_gpi;
  wire [15:0] rd_mux = rh_ctl ? ctrl_reg :
                       rh_gpi ? mioc_pkg::mioc_pack(gpi_seen) :
                       rh_gpo ? mioc_pkg::mioc_pack(gpo_reg) :
                       rh_p1 ? {4'h0, pre1_reg} :
                       rh_p2 ? {4'h0, pre2_reg} :
                       rh_adc ? {4'h0, adc_arr[rd_adc_idx]} :
                       rh_dac ? {4'h0, mem_bus.rd_data} : 16'h0000;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      ctrl_reg <= mioc_pkg::CTL_RESET;
      gpo_reg <= mioc_pkg::GPO_RESET;
      pre1_reg <= mioc_pkg::PRESET_RESET;
      pre2_reg <= mioc_pkg::PRESET_RESET;
      cur_addr_reg <= 8'h00;
      clr_req_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      gpo_reg <= gpo_next;
      pre1_reg <= pre1_next;
      pre2_reg <= pre2_next;
      cur_addr_reg <= cur_addr_next;
      clr_req_reg <= clr_req_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      acc_rvalid_reg <= 1'b0;
      acc_rdata_reg <= 16'h0000;
    end else begin
      rd_pend_reg <= rd_word;
      rd_addr_reg <= cur_addr_reg;
      acc_rvalid_reg <= rd_pend_reg;
      acc_rdata_reg <= rd_pend_reg ? rd_mux : acc_rdata_reg;
    end
  end

  // Outputs; high impedance covers the reset pulse as well
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      dev_reset_reg <= 1'b0;
      hiz_reg <= 1'b1;
      powerup_reg <= 1'b0;
      out_level_reg <= mioc_pkg::GPO_RESET;
      use_preset_reg <= 1'b0;
      preset_code_reg <= mioc_pkg::CODE_RESET;
    end else begin
      dev_reset_reg <= clr_req_reg;
      hiz_reg <= ctrl_reg[mioc_pkg::CTL_LP] || clr_req_reg;
      powerup_reg <= lp_exit;
      out_level_reg <= gpo_reg & is_gpo;
      use_preset_reg <= dac_mode[1];
      preset_code_reg <= (dac_mode == mioc_pkg::DAC_MODE_PRESET_TWO) ? pre2_reg : pre1_reg;
    end
  end

  assign acc_rdata = acc_rdata_reg;
  assign acc_rvalid = acc_rvalid_reg;
  assign acc_cur_addr = cur_addr_reg;
  assign port_out_level = out_level_reg;
  assign analog_hiz = hiz_reg;
  assign ctrl_word = ctrl_reg;
  assign monitor_enable = ctrl_reg[mioc_pkg::CTL_MON_LO +: mioc_pkg::MON_W];
  assign dac_use_preset = use_preset_reg;
  assign dac_preset_code = preset_code_reg;
  assign dev_reset = dev_reset_reg;
  assign powerup_seq = powerup_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_hot;
    ctrl_reg[7] && ctrl_reg[8] && temp_valid && (int_temp > mioc_pkg::TSHDN_LIMIT_CODE) &&
    !clr_req_reg;
  endsequence
  sequence s_cleared;
    dev_reset && analog_hiz && (ctrl_reg == mioc_pkg::CTL_RESET) && (gpo_reg == 12'h000);
  endsequence

  a_trip_reset:
  assert property (s_hot |-> ##1 clr_req_reg ##1 s_cleared)
    else $error("thermal trip did not reset");
  a_trip_clears:
  assert property (clr_req_reg |=> s_cleared and (pre1_reg == 12'h000))
    else $error("reset left state behind");
  a_no_temp_reset:
  assert property (!ctrl_reg[7] && !soft_req |=> !clr_req_reg)
    else $error("reset with thermal shutdown off");
  a_lp_hiz:
  assert property (ctrl_reg[13] |=> analog_hiz)
    else $error("low power without high impedance");
  a_lp_exit:
  assert property (lp_exit |=> powerup_seq && !ctrl_reg[13])
    else $error("no power-on sequence on exit");
  a_burst_inc:
  assert property (word_ok && !burst_ctx |=> cur_addr_reg == 8'($past(cur_addr_reg) + 8'h01))
    else $error("address did not step by one");
  a_ctx_write:
  assert property (ctx_dac |=> cur_addr_reg == mioc_pkg::OFS_DAC_END || (in_dac && is_dac[dac_idx]))
    else $error("contextual write hit wrong port");
  a_dac_read_inc:
  assert property (rd_word && in_dac |=> cur_addr_reg == 8'($past(cur_addr_reg) + 8'h01))
    else $error("output data read skipped");
  a_soft_clear:
  assert property (soft_req |=> clr_req_reg ##1 (s_cleared and !ctrl_reg[15]))
    else $error("soft reset misbehaved");
  a_gpo_drive:
  assert property (##1 port_out_level == $past(gpo_reg & is_gpo))
    else $error("output level mismatch");
  a_preset_keep:
  assert property (wr_word && (hit_pre1 || hit_pre2) |-> !mem_bus.wr_en)
    else $error("preset write touched port data");
  a_preset_sel:
  assert property (ctrl_reg[3:2] == 2'b11 |=> dac_use_preset && dac_preset_code == $past(pre2_reg))
    else $error("wrong preset selected");
endmodule // mioc_regs
`default_nettype wire

// [tb/mioc_host.sv]
`timescale 1ns/10ps
`default_nettype none
module mioc_host (
  // Clock
  input wire logic mclk,
  // Requests
  output logic acc_start,
  output logic [7:0] acc_addr,
  output logic acc_write,
  output logic acc_word,
  output logic [15:0] acc_wdata,
  // Answers
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid
);
  // ------------------------------------------------------------
  // Word driver
  // ------------------------------------------------------------
  initial
  begin
    acc_start = 1'b0;
    acc_addr = 8'h00;
    acc_write = 1'b0;
    acc_word = 1'b0;
    acc_wdata = 16'h0000;
  end

  task automatic start(input logic [7:0] a);
    @(negedge mclk);
    acc_start = 1'b1;
    acc_addr = a;
  endtask

  // Idle address and data are inverted so stale values never pass
  task automatic xfer(input logic wr, input logic [15:0] d, output logic [15:0] rd);
    int n;
    @(negedge mclk);
    acc_start = 1'b0;
    acc_addr = ~acc_addr;
    acc_word = 1'b1;
    acc_write = wr;
    acc_wdata = d;
    @(negedge mclk);
    acc_word = 1'b0;
    acc_wdata = ~d;
    rd = 16'hxxxx;
    n = 0;
    while (!wr && n < 4 && acc_rvalid !== 1'b1)
    begin
      @(negedge mclk);
      n++;
    end
    if (!wr && acc_rvalid === 1'b1)
      rd = acc_rdata;
  endtask
endmodule // mioc_host
`default_nettype wire

// [tb/mixed_io_control_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module mixed_io_control_regs_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic mclk, rst_n, acc_start, acc_write, acc_word, acc_rvalid, temp_valid;
  logic analog_hiz, dev_reset, powerup_seq, dac_use_preset;
  logic [7:0] acc_addr, acc_cur_addr;
  logic [15:0] acc_wdata, acc_rdata, ctrl_word, rd, w;
  logic [47:0] port_mode;
  logic [11:0] port_in_level, port_out_level, dac_preset_code, l, m, p1, p2, d1, d2;
  logic [143:0] adc_result;
  logic [2:0] monitor_enable;
  logic signed [11:0] int_temp;
  logic [31:0] seed = 32'h0000aaa4;
  int fail_count = 0, n_compared = 0, nrst = 0, npup = 0, k;

  mioc_regs u_dut (.mclk, .rst_n, .acc_start, .acc_addr, .acc_write, .acc_word,
    .acc_wdata, .acc_rdata, .acc_rvalid, .acc_cur_addr, .port_mode, .port_in_level,
    .adc_result, .port_out_level, .analog_hiz, .temp_valid, .int_temp, .ctrl_word,
    .monitor_enable, .dac_use_preset, .dac_preset_code, .dev_reset, .powerup_seq);
  mioc_host u_host (.mclk, .acc_start, .acc_addr, .acc_write, .acc_word, .acc_wdata,
    .acc_rdata, .acc_rvalid);

  always #5 mclk = ~mclk;

  // Pulses last one cycle, so they are counted rather than polled
  always @(posedge mclk)
  begin
    if (dev_reset === 1'b1)
      nrst <= nrst + 1;
    if (powerup_seq === 1'b1)
      npup <= npup + 1;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] pk(input logic [11:0] v);
    return {v[10:6], 3'h0, v[5:0], 1'b0, v[11]};
  endfunction

  function automatic logic [11:0] up(input logic [15:0] v);
    return {v[0], v[15:11], v[7:2]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ca(input logic [7:0] e);
    chk("cur addr", {8'h00, e}, {8'h00, acc_cur_addr});
  endtask

  task automatic settle();
    repeat (4) @(negedge mclk);
  endtask

  task automatic acc(input logic [7:0] a, input logic wr, input logic [15:0] d);
    u_host.start(a);
    u_host.xfer(wr, d, rd);
    if (wr)
      settle();
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    port_mode = 48'h0;
    port_in_level = 12'h000;
    adc_result = 144'h0;
    temp_valid = 1'b0;
    int_temp = 12'sh000;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    acc(mioc_pkg::OFS_CTRL, 1'b0, 16'h0000);
    chk("ctrl reset", 16'h0000, rd);
    chk("hiz reset", 16'h0000, {15'h0000, analog_hiz});
    acc(8'h30, 1'b0, 16'h0000);
    chk("unmapped", 16'h0000, rd);
    done("defaults");
    for (int i = 0; i < 5; i++)
    begin
      w = (i == 0) ? 16'h5fff : 16'(xs()) & 16'h5fff;
      acc(mioc_pkg::OFS_CTRL, 1'b1, w);
      acc(mioc_pkg::OFS_CTRL, 1'b0, 16'h0000);
      chk("ctrl read", w, rd);
      chk("ctrl word", w, ctrl_word);
      chk("monitors", {13'h0000, w[10:8]}, {13'h0000, monitor_enable});
    end
    port_mode = {12{4'hb}};
    for (int i = 0; i < 4; i++)
    begin
      l = (i == 0) ? 12'hfff : 12'(xs());
      port_in_level = l;
      settle();
      acc(mioc_pkg::OFS_GPI_DATA, 1'b0, 16'h0000);
      chk("input word", pk(l), rd);
    end
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 0) ? 12'hfff : 12'(xs());
      w = (i == 0) ? 16'hffff : 16'(xs());
      for (int j = 0; j < 12; j++)
        port_mode[4*j +: 4] = m[j] ? 4'hc : 4'h0;
      acc(mioc_pkg::OFS_GPO_DATA, 1'b1, w);
      acc(mioc_pkg::OFS_GPO_DATA, 1'b0, 16'h0000);
      chk("output word", w & 16'hf8fd, rd);
      chk("output pins", {4'h0, up(w) & m}, {4'h0, port_out_level});
    end
    done("levels");
    // Only ports 0 and 5 are output-converter ports
    port_mode = 48'h0;
    port_mode[3:0] = 4'h1;
    port_mode[23:20] = 4'ha;
    {d1, d2, p1, p2} = 48'({xs(), xs()});
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h4000);
    u_host.start(mioc_pkg::OFS_DAC_BASE);
    u_host.xfer(1'b1, {4'h0, d1}, rd);
    ca(8'h65);
    u_host.xfer(1'b1, {4'h0, d2}, rd);
    ca(8'h6c);
    acc(mioc_pkg::OFS_DAC_BASE, 1'b0, 16'h0000);
    chk("dac word", {4'h0, d1}, rd);
    ca(8'h61);
    acc(mioc_pkg::OFS_PRESET_ONE, 1'b1, {4'h0, p1});
    acc(mioc_pkg::OFS_PRESET_TWO, 1'b1, {4'hf, p2});
    acc(mioc_pkg::OFS_PRESET_TWO, 1'b0, 16'h0000);
    chk("preset two", {4'h0, p2}, rd);
    acc(8'h65, 1'b0, 16'h0000);
    chk("dac kept", {4'h0, d2}, rd);
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h4008);
    chk("use preset", 16'h0001, {15'h0000, dac_use_preset});
    chk("preset one out", {4'h0, p1}, {4'h0, dac_preset_code});
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h400c);
    chk("preset two out", {4'h0, p2}, {4'h0, dac_preset_code});
    done("presets");
    // Converter inputs on ports 2 and 9 only
    port_mode = 48'h0;
    port_mode[11:8] = 4'h7;
    port_mode[39:36] = 4'h7;
    for (int j = 0; j < 12; j++)
      adc_result[12*j +: 12] = 12'(xs());
    u_host.start(8'h42);
    u_host.xfer(1'b0, 16'h0000, rd);
    chk("adc port 2", {4'h0, adc_result[35:24]}, rd);
    ca(8'h49);
    u_host.xfer(1'b0, 16'h0000, rd);
    chk("adc port 9", {4'h0, adc_result[119:108]}, rd);
    ca(8'h4c);
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h0000);
    acc(8'h42, 1'b0, 16'h0000);
    ca(8'h43);
    done("burst");
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h2000);
    chk("hiz low power", 16'h0001, {15'h0000, analog_hiz});
    k = npup;
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h0000);
    chk("power-up pulses", 16'h0001, 16'(npup - k));
    chk("hiz normal", 16'h0000, {15'h0000, analog_hiz});
    port_mode = {12{4'hc}};
    acc(mioc_pkg::OFS_GPO_DATA, 1'b1, 16'hffff);
    k = nrst;
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h8100);
    chk("soft resets", 16'h0001, 16'(nrst - k));
    chk("ctrl soft", 16'h0000, ctrl_word);
    chk("pins soft", 16'h0000, {4'h0, port_out_level});
    done("power");
    // Trip needs strictly above the limit
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h0180);
    temp_valid = 1'b1;
    int_temp = 12'sh488;
    k = nrst;
    settle();
    chk("at limit", 16'h0180, ctrl_word);
    int_temp = 12'sh489;
    settle();
    chk("trips", 16'h0001, 16'(nrst - k));
    chk("ctrl trip", 16'h0000, ctrl_word);
    acc(mioc_pkg::OFS_CTRL, 1'b1, 16'h0100);
    int_temp = 12'sh7d0;
    settle();
    chk("trip off", 16'h0100, ctrl_word);
    temp_valid = 1'b0;
    done("thermal");
    complete_run();
  end

  // Roughly seventy times the expected run length
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("BAD watchdog expected done seen hang");
    complete_run();
  end
endmodule // mixed_io_control_regs_tb
`default_nettype wire
